// >>> design/ldr_device.sv
// Control and register logic of a three-channel hysteretic LED driver.
// Assumes pins and comparator results arrive asynchronously; the
// supply measurement arrives from logic on sys_clk with a valid strobe.
//
// Behaviour
// - Operation drops to undervoltage below threshold.
// - Undervoltage disables all outputs and gate supply.
// - Overtemperature or gate fault enters fail-silent; logic does so only from operation mode, not from undervoltage or off.
// - Fail-silent disables outputs, serial port stays.
// - Switch off above upper, on below lower.
// - Hysteresis width programmable per channel.
// - Supply measurement code readable at 0x38.
// - Measurement code zero means no result.
// - Code scales 0.3548 V per step minus 0.56.
// - Write to measurement raises no error.
// - Supply flag high above threshold, low below.
// - Threshold code writable at 0x0F, same scale.
// - Range bits 2:0 at 0x05 select sense.
// - Host writes zeros to range bits 7:3.
// - Target codes at 0x02, 0x03, 0x04.
// - Target code scale depends on range bit.
// - Host should prefer the low range.
// - Off mode disables serial port and outputs.
// - Leave off only with enable and power-on.
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module ldr_device
	import ldr_pkg::*;
(
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic nrst,
	// Serial link.
	ldr_link_if.dev link,
	// Chip pins and analog flags.
	input wire logic enable,
	input wire logic supply_above_pon,
	input wire logic supply_above_poff,
	input wire logic over_temp,
	input wire logic gate_fault,
	input wire logic [2:0] current_above_upper,
	input wire logic [2:0] current_below_lower,
	// Supply measurement from the converter.
	input wire logic meas_valid,
	input wire logic [7:0] meas_code,
	// Analog settings and drive outputs.
	output logic [2:0] gate_drive,
	output logic gate_supply_en,
	output logic [7:0] target_code_ch_one,
	output logic [7:0] target_code_ch_two,
	output logic [7:0] target_code_ch_three,
	output logic [2:0] range_sel,
	output logic [5:0] hyst_sel,
	output logic supply_ok_flag,
	output logic spi_error,
	output logic [1:0] mode_out
);

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic [13:0] s1;
		logic [13:0] s2;
		logic sclk_d;
		ldr_mode_e mode;
		logic [4:0] cnt;
		logic [15:0] shin;
		logic [7:0] shout;
		logic sdo;
		logic sdo_oe;
		logic [2:0][7:0] tgt;
		logic [2:0][7:0] hyst;
		logic [7:0] range;
		logic [7:0] thr;
		logic [7:0] meas;
		logic err;
		logic [2:0] gate;
		logic gsup;
	} ldr_dev_s;

	ldr_dev_s q, d;

	// Registers that the host may write.
	function automatic logic is_rw(input logic [6:0] a);
		if (a >= LDR_A_TGT1 && a <= LDR_A_RANGE) begin
			is_rw = 1'b1;
		end else if (a >= LDR_A_HYST1 && a <= LDR_A_HYST3) begin
			is_rw = 1'b1;
		end else begin
			is_rw = (a == LDR_A_THR);
		end
	endfunction

	// Read value of any register; unmapped reads give zero.
	function automatic logic [7:0] rd_reg(input ldr_dev_s s, input logic [6:0] a, input logic ok);
		if (a >= LDR_A_TGT1 && a <= LDR_A_TGT3) begin
			rd_reg = s.tgt[2'(a - LDR_A_TGT1)];
		end else if (a == LDR_A_RANGE) begin
			rd_reg = s.range;
		end else if (a >= LDR_A_HYST1 && a <= LDR_A_HYST3) begin
			rd_reg = s.hyst[2'(a - LDR_A_HYST1)];
		end else if (a == LDR_A_THR) begin
			rd_reg = s.thr;
		end else if (a == LDR_A_MEAS) begin
			rd_reg = s.meas;
		end else if (a == LDR_A_STAT) begin
			rd_reg = {4'h0, s.mode == LDR_FAIL, s.mode == LDR_UV, s.err, ok};
		end else begin
			rd_reg = 8'h00;
		end
	endfunction

	// ****************************************************************
	// Next-state logic
	// ****************************************************************
	logic ok;
	logic rise;
	logic fall;
	logic [15:0] frame;

	// A zero code means no result yet, so it never trips undervoltage.
	assign ok = (q.meas == LDR_MEAS_NONE) || (q.meas >= q.thr);

	// Edges are found on the second synchroniser stage only.
	assign rise = q.s2[LDR_P_SCLK] & ~q.sclk_d;
	assign fall = ~q.s2[LDR_P_SCLK] & q.sclk_d;
	assign frame = {q.shin[14:0], q.s2[LDR_P_SDI]};

	always_comb begin
		d = q;
		d.s1 = {link.sclk, link.csb_n, link.sdi, enable, supply_above_pon,
			supply_above_poff, over_temp, gate_fault, current_above_upper,
			current_below_lower};
		d.s2 = q.s1;
		d.sclk_d = q.s2[LDR_P_SCLK];
		if (meas_valid) begin
			d.meas = meas_code;
		end

		// Mode machine; fail-silent only leaves through off mode.
		if (!q.s2[LDR_P_EN] || !q.s2[LDR_P_POFF]) begin
			d.mode = LDR_OFF;
		end else begin
			case (q.mode)
				LDR_OFF: begin
					if (q.s2[LDR_P_PON]) begin
						d.mode = LDR_OP;
					end
				end
				LDR_OP: begin
					if (q.s2[LDR_P_OT] || q.s2[LDR_P_GF]) begin
						d.mode = LDR_FAIL;
					end else if (!ok) begin
						d.mode = LDR_UV;
					end
				end
				LDR_UV: begin
					if (ok) begin
						d.mode = LDR_OP;
					end
				end
				default: begin
					d.mode = LDR_FAIL;
				end
			endcase
		end

		// Hysteretic switch control, only alive in operation mode.
		for (int i = 0; i < 3; i++) begin
			if (d.mode != LDR_OP) begin
				d.gate[i] = 1'b0;
			end else if (q.s2[LDR_P_UP + i]) begin
				d.gate[i] = 1'b0;
			end else if (q.s2[LDR_P_LO + i]) begin
				d.gate[i] = 1'b1;
			end
		end
		d.gsup = (d.mode == LDR_OP);

		// Serial slave: shut in off mode, alive in every other mode.
		if (q.mode == LDR_OFF || q.s2[LDR_P_CSB]) begin
			d.cnt = 5'h00;
			d.sdo = 1'b0;
			d.sdo_oe = 1'b0;
		end else begin
			d.sdo_oe = 1'b1;
			if (rise) begin
				d.shin = frame;
				d.cnt = q.cnt + 5'h01;
				if (q.cnt == LDR_CNT_ADDR) begin
					d.shout = rd_reg(q, frame[6:0], ok);
					if (frame[6:0] == LDR_A_STAT) begin
						d.err = 1'b0;
					end
					if (!frame[7] && !is_rw(frame[6:0]) && frame[6:0] != LDR_A_MEAS
						&& frame[6:0] != LDR_A_STAT) begin
						d.err = 1'b1;
					end
				end
				if (q.cnt == LDR_CNT_LAST && frame[LDR_F_WR]) begin
					if (frame[14:8] >= LDR_A_TGT1 && frame[14:8] <= LDR_A_TGT3) begin
						d.tgt[2'(frame[14:8] - LDR_A_TGT1)] = frame[7:0];
					end else if (frame[14:8] == LDR_A_RANGE) begin
						d.range = frame[7:0] & LDR_RANGE_MASK;
					end else if (frame[14:8] >= LDR_A_HYST1 && frame[14:8] <= LDR_A_HYST3) begin
						d.hyst[2'(frame[14:8] - LDR_A_HYST1)] = frame[7:0] & LDR_HYST_MASK;
					end else if (frame[14:8] == LDR_A_THR) begin
						d.thr = frame[7:0];
					end else if (frame[14:8] != LDR_A_MEAS) begin
						d.err = 1'b1;
					end
				end
			end
			// Read data leaves on falling edges after the address byte.
			if (fall && q.cnt >= LDR_CNT_DATA) begin
				d.sdo = q.shout[7];
				d.shout = {q.shout[6:0], 1'b0};
			end
		end
	end

	// ****************************************************************
	// Registers; settings survive every mode change.
	// ****************************************************************
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			q <= '{s1: LDR_PIN_RST, s2: LDR_PIN_RST, mode: LDR_OFF, default: '0};
		end else begin
			q <= d;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign link.sdo = q.sdo;
	assign link.sdo_oe = q.sdo_oe;
	assign gate_drive = q.gate;
	assign gate_supply_en = q.gsup;
	assign target_code_ch_one = q.tgt[0];
	assign target_code_ch_two = q.tgt[1];
	assign target_code_ch_three = q.tgt[2];
	assign range_sel = q.range[2:0];
	assign hyst_sel = {q.hyst[2][1:0], q.hyst[1][1:0], q.hyst[0][1:0]};
	assign supply_ok_flag = ok;
	assign spi_error = q.err;
	assign mode_out = 2'(q.mode);

endmodule
`default_nettype wire

// >>> design/ldr_pkg.sv
// Shared constants for both ends of the LED driver control link.
// Assumes a 100 MHz system clock at both ends and a 16-bit serial frame.
package ldr_pkg;

	// ****************************************************************
	// Device register map (7-bit serial addresses)
	// ****************************************************************
	localparam logic [6:0] LDR_A_TGT1 = 7'h02;
	localparam logic [6:0] LDR_A_TGT2 = 7'h03;
	localparam logic [6:0] LDR_A_TGT3 = 7'h04;
	localparam logic [6:0] LDR_A_RANGE = 7'h05;
	localparam logic [6:0] LDR_A_HYST1 = 7'h0B;
	localparam logic [6:0] LDR_A_HYST2 = 7'h0C;
	localparam logic [6:0] LDR_A_HYST3 = 7'h0D;
	localparam logic [6:0] LDR_A_THR = 7'h0F;
	localparam logic [6:0] LDR_A_MEAS = 7'h38;
	localparam logic [6:0] LDR_A_STAT = 7'h3A;

	// ****************************************************************
	// Field positions and reset values
	// ****************************************************************
	localparam logic [7:0] LDR_RANGE_MASK = 8'h07;
	localparam logic [7:0] LDR_HYST_MASK = 8'h03;
	localparam logic [7:0] LDR_REG_RST = 8'h00;
	localparam logic [7:0] LDR_MEAS_NONE = 8'h00;
	localparam int LDR_ST_OK = 0;
	localparam int LDR_ST_ERR = 1;
	localparam int LDR_ST_UV = 2;
	localparam int LDR_ST_FAIL = 3;

	// ****************************************************************
	// Frame layout: bit 15 write, bits 14:8 address, bits 7:0 data
	// ****************************************************************
	localparam int LDR_FRAME_BITS = 16;
	localparam int LDR_F_WR = 15;
	localparam logic [4:0] LDR_CNT_ADDR = 5'h07;
	localparam logic [4:0] LDR_CNT_LAST = 5'h0F;
	localparam logic [4:0] LDR_CNT_DATA = 5'h08;

	// ****************************************************************
	// Device pin synchroniser bit positions
	// ****************************************************************
	localparam int LDR_P_SCLK = 13;
	localparam int LDR_P_CSB = 12;
	localparam int LDR_P_SDI = 11;
	localparam int LDR_P_EN = 10;
	localparam int LDR_P_PON = 9;
	localparam int LDR_P_POFF = 8;
	localparam int LDR_P_OT = 7;
	localparam int LDR_P_GF = 6;
	localparam int LDR_P_UP = 3;
	localparam int LDR_P_LO = 0;
	localparam logic [13:0] LDR_PIN_RST = 14'h1000;

	// ****************************************************************
	// Controller timing and APB map
	// ****************************************************************
	localparam int LDR_CLK_NS = 10;
	localparam int LDR_SCLK_NS = 80;
	localparam logic [1:0] LDR_HALF_CYC = 2'((LDR_SCLK_NS / 2) / LDR_CLK_NS - 1);
	localparam logic [7:0] LDR_APB_CMD = 8'h00;
	localparam logic [7:0] LDR_APB_STAT = 8'h04;

	typedef enum {LDR_OFF, LDR_OP, LDR_UV, LDR_FAIL} ldr_mode_e;
	typedef enum {LDR_IDLE, LDR_RUN, LDR_GAP} ldr_ctl_e;

endpackage

// >>> design/ldr_link_if.sv
// Serial link between the LED driver device and its controller.
// Assumes both ends run on their own copy of a 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
interface ldr_link_if;
	logic sclk;
	logic csb_n;
	logic sdi;
	logic sdo;
	logic sdo_oe;
	logic sdo_line;

	// An undriven data-out line reads low.
	assign sdo_line = sdo_oe ? sdo : 1'b0;

	modport dev (input sclk, input csb_n, input sdi, output sdo, output sdo_oe);
	modport ctl (output sclk, output csb_n, output sdi, input sdo_line);
endinterface
`default_nettype wire

// >>> design/ldr_ctrl.sv
// Controller end: an APB slave that runs 16-bit frames on the link.
// Assumes the device samples on rising and shifts on falling sclk.
`timescale 1ns/1ps
`default_nettype none
module ldr_ctrl
	import ldr_pkg::*;
(
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic nrst,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Serial link.
	ldr_link_if.ctl link
);

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		ldr_ctl_e st;
		logic [1:0] div;
		logic sclk;
		logic csb_n;
		logic sdi;
		logic [4:0] cnt;
		logic [15:0] tx;
		logic [7:0] rx;
		logic sdo_s1;
		logic sdo_s2;
		logic [31:0] rdata;
		logic serr;
	} ldr_ctl_s;

	ldr_ctl_s q, d;
	logic tick;
	logic setup;

	assign tick = (q.div == LDR_HALF_CYC);
	assign setup = psel & ~penable;

	// ****************************************************************
	// Next-state logic
	// ****************************************************************
	always_comb begin
		d = q;
		d.sdo_s1 = link.sdo_line;
		d.sdo_s2 = q.sdo_s1;
		d.div = (q.st == LDR_IDLE || tick) ? 2'h0 : q.div + 2'h1;

		// Read data and error are latched in the setup cycle.
		if (setup) begin
			d.serr = !(paddr == LDR_APB_CMD || paddr == LDR_APB_STAT);
			d.rdata = (paddr == LDR_APB_STAT) ?
				{16'h0000, q.rx, 7'h00, q.st != LDR_IDLE} : 32'h0000_0000;
		end

		case (q.st)
			LDR_IDLE: begin
				// A command written while a frame runs is dropped.
				if (psel && penable && pwrite && paddr == LDR_APB_CMD) begin
					d.st = LDR_RUN;
					d.tx = pwdata[15:0];
					d.csb_n = 1'b0;
					d.sdi = pwdata[LDR_F_WR];
					d.cnt = 5'h00;
				end
			end
			LDR_RUN: begin
				if (tick) begin
					d.sclk = ~q.sclk;
					// Sample late in the high phase, past the sync delay.
					if (q.sclk) begin
						d.rx = {q.rx[6:0], q.sdo_s2};
						d.tx = {q.tx[14:0], 1'b0};
						d.sdi = q.tx[14];
						d.cnt = q.cnt + 5'h01;
						if (q.cnt == LDR_CNT_LAST) begin
							d.st = LDR_GAP;
							d.csb_n = 1'b1;
							d.sdi = 1'b0;
						end
					end
				end
			end
			default: begin
				// Keep chip select high for one half period between frames.
				if (tick) begin
					d.st = LDR_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			q <= '{st: LDR_IDLE, csb_n: 1'b1, default: '0};
		end else begin
			q <= d;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign pready = 1'b1;
	assign prdata = q.rdata;
	assign pslverr = q.serr;
	assign link.sclk = q.sclk;
	assign link.csb_n = q.csb_n;
	assign link.sdi = q.sdi;

endmodule
`default_nettype wire

// >>> test/ldr_chk_sva.sv
// Checker for the LED driver link and the device mode outputs.
// Assumes one sys_clk domain; the bench top hands it the signals.
`timescale 1ns/1ps
`default_nettype none
module ldr_chk_sva (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic nrst,
	// Link.
	input wire logic sclk,
	input wire logic csb_n,
	input wire logic sdo_oe,
	// Device pins.
	input wire logic enable,
	input wire logic over_temp,
	input wire logic gate_fault,
	input wire logic [2:0] current_above_upper,
	input wire logic [2:0] current_below_lower,
	input wire logic [1:0] mode_out,
	input wire logic [2:0] gate_drive,
	input wire logic gate_supply_en,
	input wire logic supply_ok_flag
);
	// ****************************************************************
	// Shared sequences
	// ****************************************************************
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!nrst);

	// Two cycles of settling, though gates are registered in the same cycle as mode.
	sequence s_dark;
		gate_drive == 3'h0 && !gate_supply_en;
	endsequence
	sequence s_upper;
		mode_out == 2'd1 && current_above_upper[0];
	endsequence

	// ****************************************************************
	// Assertions
	// ****************************************************************
	idle_clock_a: assert property (csb_n |-> !sclk)
		else $error("sclk moved outside a frame");
	half_period_a: assert property ($rose(sclk) |-> sclk [*4])
		else $error("sclk high phase too short");
	// The device sees chip select through two sync stages and a register.
	quiet_sdo_a: assert property (csb_n [*4] |-> !sdo_oe)
		else $error("sdo driven outside a frame");
	uv_entry_a: assert property (mode_out == 2'd1 && !supply_ok_flag |-> ##[1:3] mode_out != 2'd1)
		else $error("operation kept with supply low");
	uv_dark_a: assert property (mode_out == 2'd2 [*2] |-> s_dark)
		else $error("outputs alive in undervoltage");
	fail_entry_a: assert property ($rose(over_temp || gate_fault) && mode_out == 2'd1 |-> ##[1:6] mode_out == 2'd3)
		else $error("fault did not silence the device");
	fail_dark_a: assert property (mode_out == 2'd3 [*2] |-> s_dark)
		else $error("outputs alive in fail-silent");
	off_dark_a: assert property (mode_out == 2'd0 [*2] |-> s_dark and !sdo_oe)
		else $error("outputs alive in off mode");
	off_entry_a: assert property (!enable [*5] |=> mode_out == 2'd0)
		else $error("off mode not entered");
	gate_cut_a: assert property (s_upper [*5] |-> !gate_drive[0])
		else $error("switch kept on above upper limit");
	gate_on_a: assert property ((mode_out == 2'd1 && current_below_lower[0] && !current_above_upper[0]) [*5] |-> gate_drive[0])
		else $error("switch kept off below lower limit");
endmodule
`default_nettype wire

// >>> test/test_led_driver_mode_and_current_regs.sv
// Self-checking bench: controller and device joined over the link.
// Assumes the design package and interface are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_led_driver_mode_and_current_regs;
	import ldr_pkg::*;
	logic sys_clk, nrst, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic enable, supply_above_pon, supply_above_poff, over_temp, gate_fault, meas_valid;
	logic [2:0] current_above_upper, current_below_lower, gate_drive, range_sel;
	logic [7:0] meas_code, target_code_ch_one, target_code_ch_two, target_code_ch_three, q;
	logic [5:0] hyst_sel;
	logic gate_supply_en, supply_ok_flag, spi_error;
	logic [1:0] mode_out;
	int num_errors, checks;
	logic [6:0] ra [8] = '{LDR_A_TGT1, LDR_A_TGT2, LDR_A_TGT3, LDR_A_RANGE,
		LDR_A_HYST1, LDR_A_HYST2, LDR_A_HYST3, LDR_A_THR};
	// Range value keeps bits 7:3 clear and selects the fine range on ch1 and ch3.
	logic [7:0] rd [8] = '{8'h7E, 8'h32, 8'hF5, 8'h05, 8'h03, 8'h02, 8'h01, 8'h40};

	// ****************************************************************
	// Design and checker
	// ****************************************************************
	ldr_link_if u_ldr_link_if();
	ldr_device u_ldr_device(.sys_clk(sys_clk), .nrst(nrst), .link(u_ldr_link_if),
		.enable(enable), .supply_above_pon(supply_above_pon),
		.supply_above_poff(supply_above_poff), .over_temp(over_temp),
		.gate_fault(gate_fault), .current_above_upper(current_above_upper),
		.current_below_lower(current_below_lower), .meas_valid(meas_valid),
		.meas_code(meas_code), .gate_drive(gate_drive), .gate_supply_en(gate_supply_en),
		.target_code_ch_one(target_code_ch_one), .target_code_ch_two(target_code_ch_two),
		.target_code_ch_three(target_code_ch_three), .range_sel(range_sel),
		.hyst_sel(hyst_sel), .supply_ok_flag(supply_ok_flag), .spi_error(spi_error),
		.mode_out(mode_out));
	ldr_ctrl u_ldr_ctrl(.sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .link(u_ldr_link_if));
	ldr_chk_sva u_ldr_chk_sva(.sys_clk(sys_clk), .nrst(nrst), .sclk(u_ldr_link_if.sclk),
		.csb_n(u_ldr_link_if.csb_n), .sdo_oe(u_ldr_link_if.sdo_oe), .enable(enable),
		.over_temp(over_temp), .gate_fault(gate_fault),
		.current_above_upper(current_above_upper), .current_below_lower(current_below_lower),
		.mode_out(mode_out), .gate_drive(gate_drive), .gate_supply_en(gate_supply_en),
		.supply_ok_flag(supply_ok_flag));

	// The 100 MHz clock.
	always #5 sys_clk = ~sys_clk;

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// One whole frame; the pause keeps chip select high long enough between frames.
	task automatic xfer(input logic w, input logic [6:0] a, input logic [7:0] d);
		apb(1'b1, LDR_APB_CMD, {16'h0, w, a, d});
		do apb(1'b0, LDR_APB_STAT, 32'h0); while (r[0] !== 1'b0);
		q = r[15:8];
		repeat (6) @(posedge sys_clk);
	endtask
	task automatic meas(input logic [7:0] c);
		@(posedge sys_clk);
		meas_valid <= 1'b1;
		meas_code <= c;
		@(posedge sys_clk);
		meas_valid <= 1'b0;
		repeat (4) @(posedge sys_clk);
	endtask
	task automatic pins(input logic [2:0] m);
		{enable, over_temp, gate_fault} <= m;
		repeat (8) @(posedge sys_clk);
	endtask
	task test_done;
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Watchdog against a hung handshake.
	initial begin
		repeat (30000) @(posedge sys_clk);
		num_errors++;
		test_done;
	end

	// Main sequence.
	initial begin
		{sys_clk, nrst, psel, penable, pwrite, paddr, pwdata} = '0;
		{enable, over_temp, gate_fault, meas_valid, meas_code} = '0;
		{current_above_upper, current_below_lower} = '0;
		{supply_above_pon, supply_above_poff} = 2'b11;
		repeat (4) @(posedge sys_clk);
		nrst <= 1'b1;
		repeat (8) @(posedge sys_clk);
		chk(8'(mode_out), 8'h00);
		xfer(1'b1, LDR_A_TGT1, 8'h55);
		pins(3'b100);
		chk(8'(mode_out), 8'h01);
		apb(1'b0, 8'h08, 32'h0);
		chk(8'(pslverr), 8'h01);
		for (int i = 0; i < 8; i++) begin
			xfer(1'b0, ra[i], 8'h00);
			chk(q, 8'h00);
			xfer(1'b1, ra[i], rd[i]);
			xfer(1'b0, ra[i], 8'h00);
			chk(q, rd[i]);
		end
		chk(target_code_ch_one, 8'h7E);
		chk(target_code_ch_two, 8'h32);
		chk(target_code_ch_three, 8'hF5);
		chk({range_sel, 5'h00}, 8'hA0);
		chk({hyst_sel, 2'b00}, 8'h6C);
		xfer(1'b0, LDR_A_MEAS, 8'h00);
		chk(q, LDR_MEAS_NONE);
		chk(8'(supply_ok_flag), 8'h01);
		meas(8'h80);
		xfer(1'b1, LDR_A_MEAS, 8'h12);
		chk(8'(spi_error), 8'h00);
		xfer(1'b0, LDR_A_MEAS, 8'h00);
		chk(q, 8'h80);
		xfer(1'b1, 7'h10, 8'h01);
		chk(8'(spi_error), 8'h01);
		xfer(1'b0, LDR_A_STAT, 8'h00);
		chk(8'(spi_error), 8'h00);
		// Fall under the threshold, then return at exactly the threshold.
		meas(8'h3F);
		chk(8'(supply_ok_flag), 8'h00);
		chk(8'(mode_out), 8'h02);
		chk({gate_drive, gate_supply_en}, 4'h0);
		// Status shows undervoltage with the supply flag low.
		xfer(1'b0, LDR_A_STAT, 8'h00);
		chk(q, 8'h04);
		meas(8'h40);
		chk(8'(supply_ok_flag), 8'h01);
		xfer(1'b0, LDR_A_TGT1, 8'h00);
		chk(q, 8'h7E);
		chk(8'(mode_out), 8'h01);
		current_below_lower <= 3'h7;
		pins(3'b100);
		chk({gate_drive, gate_supply_en}, 4'hF);
		current_above_upper <= 3'h1;
		pins(3'b100);
		chk(8'(gate_drive), 8'h06);
		pins(3'b110);
		chk(8'(mode_out), 8'h03);
		chk({gate_drive, gate_supply_en}, 4'h0);
		xfer(1'b1, LDR_A_TGT2, 8'h11);
		xfer(1'b0, LDR_A_TGT2, 8'h00);
		chk(q, 8'h11);
		xfer(1'b0, LDR_A_TGT1, 8'h00);
		chk(q, 8'h7E);
		// Status shows fail-silent with the supply still good.
		xfer(1'b0, LDR_A_STAT, 8'h00);
		chk(q, 8'h09);
		pins(3'b100);
		chk(8'(mode_out), 8'h03);
		pins(3'b000);
		chk(8'(mode_out), 8'h00);
		xfer(1'b0, LDR_A_TGT1, 8'h00);
		chk(q, 8'h00);
		pins(3'b100);
		chk(8'(mode_out), 8'h01);
		pins(3'b101);
		chk(8'(mode_out), 8'h03);
		// Supply below the power-off level forces off mode even when enabled.
		supply_above_poff <= 1'b0;
		pins(3'b100);
		chk(8'(mode_out), 8'h00);
		// Enable alone is not enough without the power-on level.
		supply_above_pon <= 1'b0;
		supply_above_poff <= 1'b1;
		pins(3'b100);
		chk(8'(mode_out), 8'h00);
		supply_above_pon <= 1'b1;
		pins(3'b100);
		chk(8'(mode_out), 8'h01);
		test_done;
	end
endmodule
`default_nettype wire
